// ==== rtl/fault_recorder_defines.vh ====
// Constants for the fault waveform recorder.
`ifndef FAULT_RECORDER_DEFINES_VH
`define FAULT_RECORDER_DEFINES_VH

// Samples taken per power-system cycle.
`define SAMPLES_PER_CYCLE 13'd64
// Record lengths in cycles for record-count codes 0..3.
`define REC_CYCLES_0 7'd72
`define REC_CYCLES_1 7'd36
`define REC_CYCLES_2 7'd18
`define REC_CYCLES_3 7'd12
// Record counts, standard memory.
`define STD_RECORDS_0 6'd2
`define STD_RECORDS_1 6'd4
`define STD_RECORDS_2 6'd8
`define STD_RECORDS_3 6'd12
// Record counts, expanded memory.
`define EXP_RECORDS_0 6'd6
`define EXP_RECORDS_1 6'd12
`define EXP_RECORDS_2 6'd24
`define EXP_RECORDS_3 6'd36
// Pre-trigger cycle range.
`define PRETRIG_MIN 4'd1
`define PRETRIG_MAX 4'd8
// Split percentage full scale.
`define PERCENT_FULL 7'd100
// Total memory in cycles with expanded memory fitted.
`define MEM_CYCLES 432

`endif

// ==== rtl/fault_recorder.v ====
// Fault waveform recorder: capture around triggers and ordered readout.
`timescale 1ns/1ns
`default_nettype none
`include "fault_recorder_defines.vh"
// Function
// - Oldest record overwritten once all slots used
// - Record length follows record count setting
// - Pre-trigger cycles programmable one to eight
// - Fault portion is record minus pre-trigger
// - Sixty-four samples stored per cycle
// - Long fault keeps beginning and end share
// - Split leaves pre-trigger part untouched
// - Short fault stored whole, split ignored
module fault_recorder #(
    parameter DW = 16,
    parameter AW = 15,
    parameter MEM_WORDS = `MEM_CYCLES * `SAMPLES_PER_CYCLE,
    parameter MAX_RECORDS = 36
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_srst,
    // Settings.
    input wire i_expanded_mem,
    input wire [1:0] i_record_count_setting,
    input wire [3:0] i_pretrigger_cycle_count,
    input wire [6:0] i_split_end_percentage,
    // Sample stream and fault status from protection logic.
    input wire i_sample_valid,
    input wire [DW-1:0] i_sample,
    input wire i_trigger,
    input wire i_fault_active,
    // Record readout request.
    input wire i_read_start,
    input wire [5:0] i_read_slot,
    output wire o_read_busy,
    // Readout stream.
    output wire o_out_valid,
    output reg [DW-1:0] o_out_data,
    output reg o_out_last,
    input wire i_out_ready,
    // Status.
    output wire o_capturing,
    output reg [5:0] o_stored_count,
    output reg [5:0] o_newest_slot
);
    localparam C_PRE = 2'b01, C_FAULT = 2'b10;
    localparam R_IDLE = 4'b0001, R_PRE = 4'b0010, R_HEAD = 4'b0100,
        R_TAIL = 4'b1000;
    function [6:0] rec_cycles;
        input [1:0] code;
        begin
            case (code)
                2'd0: rec_cycles = `REC_CYCLES_0;
                2'd1: rec_cycles = `REC_CYCLES_1;
                2'd2: rec_cycles = `REC_CYCLES_2;
                default: rec_cycles = `REC_CYCLES_3;
            endcase
        end
    endfunction
    function [5:0] rec_num;
        input [1:0] code;
        input expanded;
        begin
            case (code)
                2'd0: rec_num = expanded ? `EXP_RECORDS_0 : `STD_RECORDS_0;
                2'd1: rec_num = expanded ? `EXP_RECORDS_1 : `STD_RECORDS_1;
                2'd2: rec_num = expanded ? `EXP_RECORDS_2 : `STD_RECORDS_2;
                default: rec_num = expanded ? `EXP_RECORDS_3 : `STD_RECORDS_3;
            endcase
        end
    endfunction
    // Record geometry from the present settings.
    wire [5:0] records = rec_num(i_record_count_setting, i_expanded_mem);
    wire [6:0] cycles = rec_cycles(i_record_count_setting);
    wire [3:0] pre_cyc = (i_pretrigger_cycle_count < `PRETRIG_MIN) ?
        `PRETRIG_MIN : (i_pretrigger_cycle_count > `PRETRIG_MAX) ?
        `PRETRIG_MAX : i_pretrigger_cycle_count;
    wire [6:0] pct = (i_split_end_percentage > `PERCENT_FULL) ?
        `PERCENT_FULL : i_split_end_percentage;
    wire [12:0] rec_n = cycles * `SAMPLES_PER_CYCLE;
    wire [12:0] pre_n = {9'd0, pre_cyc} * `SAMPLES_PER_CYCLE;
    wire [12:0] fault_n = rec_n - pre_n;
    wire [19:0] tail_prod = fault_n * pct;
    wire [19:0] tail_div = tail_prod / {13'd0, `PERCENT_FULL};
    wire [12:0] tail_n = tail_div[12:0];
    wire [12:0] head_n = fault_n - tail_n;
    reg [DW-1:0] mem [0:MEM_WORDS-1];
    // Per-record bookkeeping.
    reg [12:0] m_pre_start [0:MAX_RECORDS-1];
    reg [12:0] m_pre_len [0:MAX_RECORDS-1];
    reg [12:0] m_fault_len [0:MAX_RECORDS-1];
    reg [12:0] m_tail_ptr [0:MAX_RECORDS-1];
    reg m_wrap [0:MAX_RECORDS-1];
    reg [MAX_RECORDS-1:0] m_valid;
    // Capture side.
    reg [1:0] cstate;
    reg [5:0] wslot;
    reg [12:0] pre_ptr, pre_fill, fcnt, tptr;
    reg wrapped;
    wire [18:0] wbase_w = wslot * rec_n;
    wire [AW-1:0] wbase = wbase_w[AW-1:0];
    wire [5:0] slot_inc = wslot + 6'd1;
    wire [5:0] slot_next = (slot_inc >= records) ? 6'd0 : slot_inc;
    reg [12:0] woff;
    reg wen;
    assign o_capturing = cstate[1];
    always @* begin
        wen = 1'b0;
        woff = 13'd0;
        if (cstate == C_PRE && i_sample_valid && !i_trigger) begin
            wen = 1'b1;
            woff = pre_ptr;
        end else if (cstate == C_FAULT && i_sample_valid && i_fault_active) begin
            if (fcnt < fault_n) begin
                wen = 1'b1;
                woff = pre_n + fcnt;
            end else if (tail_n != 13'd0) begin
                wen = 1'b1;
                woff = pre_n + head_n + tptr;
            end
        end
    end
    always @(posedge i_clk) begin
        if (i_srst) begin
            cstate <= C_PRE;
            wslot <= 6'd0;
            pre_ptr <= 13'd0;
            pre_fill <= 13'd0;
            fcnt <= 13'd0;
            tptr <= 13'd0;
            wrapped <= 1'b0;
            m_valid <= {MAX_RECORDS{1'b0}};
            o_stored_count <= 6'd0;
            o_newest_slot <= 6'd0;
        end else begin
            case (cstate)
                C_PRE: begin
                    if (i_trigger) begin
                        // Oldest pre-trigger sample is at the ring pointer once full.
                        m_pre_start[wslot] <= (pre_fill >= pre_n) ? pre_ptr : 13'd0;
                        m_pre_len[wslot] <= (pre_fill >= pre_n) ? pre_n : pre_fill;
                        m_valid[wslot] <= 1'b0;
                        fcnt <= 13'd0;
                        tptr <= 13'd0;
                        wrapped <= 1'b0;
                        cstate <= C_FAULT;
                    end else if (i_sample_valid) begin
                        // Oldest record is unreadable once refill starts.
                        m_valid[wslot] <= 1'b0;
                        pre_ptr <= (pre_ptr + 13'd1 >= pre_n) ? 13'd0 :
                            pre_ptr + 13'd1;
                        if (pre_fill < pre_n)
                            pre_fill <= pre_fill + 13'd1;
                    end
                end
                C_FAULT: begin
                    if (!i_fault_active) begin
                        m_fault_len[wslot] <= fcnt;
                        m_tail_ptr[wslot] <= tptr;
                        m_wrap[wslot] <= wrapped;
                        m_valid[wslot] <= 1'b1;
                        o_newest_slot <= wslot;
                        if (o_stored_count < records)
                            o_stored_count <= o_stored_count + 6'd1;
                        wslot <= slot_next;
                        pre_ptr <= 13'd0;
                        pre_fill <= 13'd0;
                        cstate <= C_PRE;
                    end else if (i_sample_valid) begin
                        if (fcnt < fault_n) begin
                            fcnt <= fcnt + 13'd1;
                        end else if (tail_n != 13'd0) begin
                            // End share runs as a ring over the last tail_n words.
                            wrapped <= 1'b1;
                            tptr <= (tptr + 13'd1 >= tail_n) ? 13'd0 :
                                tptr + 13'd1;
                        end
                    end
                end
                default: cstate <= C_PRE;
            endcase
        end
    end
    // Readout sequencer.
    reg [3:0] rstate;
    reg [5:0] rslot;
    reg [12:0] rptr, rleft;
    reg [13:0] rtotal;
    reg inflight, last_q;
    reg [DW-1:0] mem_q;
    reg [1:0] fcount;
    wire [18:0] rbase_w = rslot * rec_n;
    wire [AW-1:0] rbase = rbase_w[AW-1:0];
    wire rwrap = m_wrap[rslot];
    wire [12:0] hcount = rwrap ? head_n : m_fault_len[rslot];
    wire room = ({1'b0, fcount} + {2'b00, inflight}) < 3'd2;
    wire active = !rstate[0] && rleft != 13'd0;
    wire issue = active && room;
    reg [12:0] roff;
    assign o_read_busy = !rstate[0];
    always @* begin
        case (rstate)
            R_PRE: roff = rptr;
            R_HEAD: roff = pre_n + rptr;
            R_TAIL: roff = pre_n + head_n + rptr;
            default: roff = 13'd0;
        endcase
    end
    always @(posedge i_clk) begin
        if (wen)
            mem[wbase + {{(AW-13){1'b0}}, woff}] <= i_sample;
        if (issue)
            mem_q <= mem[rbase + {{(AW-13){1'b0}}, roff}];
    end
    always @(posedge i_clk) begin
        if (i_srst) begin
            rstate <= R_IDLE;
            rslot <= 6'd0;
            rptr <= 13'd0;
            rleft <= 13'd0;
            rtotal <= 14'd0;
            inflight <= 1'b0;
            last_q <= 1'b0;
        end else begin
            inflight <= issue;
            last_q <= issue && rtotal == 14'd1;
            if (issue) begin
                rleft <= rleft - 13'd1;
                rtotal <= rtotal - 14'd1;
            end
            case (rstate)
                R_IDLE: begin
                    if (i_read_start && i_read_slot < records &&
                        m_valid[i_read_slot]) begin
                        rslot <= i_read_slot;
                        rptr <= m_pre_start[i_read_slot];
                        rleft <= m_pre_len[i_read_slot];
                        rtotal <= {1'b0, m_pre_len[i_read_slot]} +
                            {1'b0, m_fault_len[i_read_slot]};
                        rstate <= R_PRE;
                    end
                end
                R_PRE: begin
                    if (rleft == 13'd0) begin
                        rptr <= 13'd0;
                        rleft <= hcount;
                        rstate <= R_HEAD;
                    end else if (issue) begin
                        rptr <= (rptr + 13'd1 >= pre_n) ? 13'd0 : rptr + 13'd1;
                    end
                end
                R_HEAD: begin
                    if (rleft == 13'd0) begin
                        rptr <= m_tail_ptr[rslot];
                        rleft <= rwrap ? tail_n : 13'd0;
                        rstate <= R_TAIL;
                    end else if (issue) begin
                        rptr <= rptr + 13'd1;
                    end
                end
                R_TAIL: begin
                    if (rleft == 13'd0) begin
                        rstate <= R_IDLE;
                    end else if (issue) begin
                        rptr <= (rptr + 13'd1 >= tail_n) ? 13'd0 :
                            rptr + 13'd1;
                    end
                end
                default: rstate <= R_IDLE;
            endcase
        end
    end
    // Two-entry buffer so a stalled receiver loses no word.
    reg [DW:0] fbuf [0:1];
    reg fwp, frp;
    wire pop = o_out_valid && i_out_ready;
    assign o_out_valid = fcount != 2'd0;
    always @(posedge i_clk) begin
        if (i_srst) begin
            fwp <= 1'b0;
            frp <= 1'b0;
            fcount <= 2'd0;
        end else begin
            if (inflight) begin
                fbuf[fwp] <= {last_q, mem_q};
                fwp <= ~fwp;
            end
            if (pop)
                frp <= ~frp;
            fcount <= fcount + {1'b0, inflight} - {1'b0, pop};
        end
    end
    always @* begin
        o_out_data = fbuf[frp][DW-1:0];
        o_out_last = o_out_valid && fbuf[frp][DW];
    end
endmodule // fault_recorder
`default_nettype wire

// ==== sim/relay_source.sv ====
// Protection-logic model feeding samples, trigger and fault state.
`timescale 1ns/1ns
`default_nettype none
module relay_source (
    // Clock.
    input wire logic i_clk,
    // Stream towards the recorder.
    output logic o_sample_valid,
    output logic [15:0] o_sample,
    output logic o_trigger,
    output logic o_fault_active
);
    logic [15:0] pre_q[$];
    logic [15:0] flt_q[$];
    initial begin
        o_sample_valid = 1'b0;
        o_sample = 16'h0000;
        o_trigger = 1'b0;
        o_fault_active = 1'b0;
    end
    task automatic put(input logic flt, input logic hold);
        logic [15:0] v;
        v = 16'($urandom);
        @(posedge i_clk);
        o_sample_valid <= 1'b1;
        o_sample <= v;
        o_fault_active <= flt;
        o_trigger <= hold;
        if (flt)
            flt_q.push_back(v);
        else
            pre_q.push_back(v);
    endtask
    // A held trigger while capturing must be ignored by the recorder.
    task automatic run_event(input int npre, input int nf, input logic hold);
        pre_q.delete();
        flt_q.delete();
        repeat (npre) put(1'b0, 1'b0);
        @(posedge i_clk);
        o_sample_valid <= 1'b0;
        o_trigger <= 1'b1;
        o_fault_active <= 1'b1;
        repeat (nf) put(1'b1, hold);
        @(posedge i_clk);
        o_sample_valid <= 1'b0;
        o_sample <= ~o_sample;
        o_trigger <= 1'b0;
        o_fault_active <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
endmodule // relay_source
`default_nettype wire

// ==== sim/fault_recorder_sva.sv ====
// Port assertions for the fault recorder.
`timescale 1ns/1ns
`default_nettype none
module fault_recorder_sva #(
    parameter DW = 16
) (
    // Clock, reset and settings.
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_expanded_mem,
    input wire logic [1:0] i_record_count_setting,
    // Capture side.
    input wire logic i_trigger,
    input wire logic i_fault_active,
    input wire logic o_capturing,
    input wire logic [5:0] o_stored_count,
    input wire logic [5:0] o_newest_slot,
    // Readout side.
    input wire logic i_read_start,
    input wire logic [5:0] i_read_slot,
    input wire logic o_read_busy,
    input wire logic o_out_valid,
    input wire logic [DW-1:0] o_out_data,
    input wire logic o_out_last,
    input wire logic i_out_ready
);
    logic [5:0] rtab [8] = '{2, 4, 8, 12, 6, 12, 24, 36};
    logic [6:0] ctab [4] = '{72, 36, 18, 12};
    logic [5:0] recs;
    logic [12:0] words;
    logic done;
    assign recs = rtab[{i_expanded_mem, i_record_count_setting}];
    assign done = o_capturing && !i_fault_active;
    always_ff @(posedge i_clk) begin
        if (i_srst || (o_out_valid && i_out_ready && o_out_last))
            words <= 13'h0000;
        else if (o_out_valid && i_out_ready)
            words <= words + 13'h0001;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_start;
        !o_capturing && i_trigger |=> o_capturing;
    endproperty
    a_start: assert property (p_start) else $error("no capture");
    property p_stand;
        o_capturing && i_fault_active |=> o_capturing;
    endproperty
    a_stand: assert property (p_stand) else $error("capture cut");
    property p_end;
        done |=> !o_capturing;
    endproperty
    a_end: assert property (p_end) else $error("capture stuck");
    property p_count;
        done |=> o_stored_count == ($past(o_stored_count) == recs ?
            recs : $past(o_stored_count) + 6'd1);
    endproperty
    a_count: assert property (p_count) else $error("bad count");
    property p_newest;
        done |=> o_newest_slot == (($past(o_stored_count) == 6'd0 ||
            $past(o_newest_slot) + 6'd1 == recs) ?
            6'd0 : $past(o_newest_slot) + 6'd1);
    endproperty
    a_newest: assert property (p_newest) else $error("bad slot");
    property p_refuse;
        i_read_start && !o_read_busy && i_read_slot >= o_stored_count
            |=> !o_read_busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad read");
    property p_hold;
        o_out_valid && !i_out_ready |=> o_out_valid &&
            $stable(o_out_data) && $stable(o_out_last);
    endproperty
    a_hold: assert property (p_hold) else $error("word lost");
    property p_len;
        o_out_valid |-> words < {ctab[i_record_count_setting], 6'h00};
    endproperty
    a_len: assert property (p_len) else $error("too long");
endmodule // fault_recorder_sva
bind fault_recorder fault_recorder_sva #(.DW(DW)) u_fault_recorder_sva (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_expanded_mem(i_expanded_mem),
    .i_record_count_setting(i_record_count_setting),
    .i_trigger(i_trigger),
    .i_fault_active(i_fault_active),
    .o_capturing(o_capturing),
    .o_stored_count(o_stored_count),
    .o_newest_slot(o_newest_slot),
    .i_read_start(i_read_start),
    .i_read_slot(i_read_slot),
    .o_read_busy(o_read_busy),
    .o_out_valid(o_out_valid),
    .o_out_data(o_out_data),
    .o_out_last(o_out_last),
    .i_out_ready(i_out_ready)
);
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the fault waveform recorder.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic srst = 1'b1;
    logic expm = 1'b0;
    logic [1:0] code = 2'd0;
    logic [3:0] pre = 4'd1;
    logic [6:0] pct = 7'd0;
    logic rs = 1'b0;
    logic [5:0] slot = 6'd0;
    logic rdy = 1'b1;
    wire logic sv, tr, fa, busy, ov, ol, cap;
    wire logic [15:0] sd, od;
    wire logic [5:0] cnt, newest;
    int failures = 0;
    int check_count = 0;
    int ctab [4] = '{72, 36, 18, 12};
    int rtab [8] = '{2, 4, 8, 12, 6, 12, 24, 36};
    always #5 i_clk = ~i_clk;
    fault_recorder u_fault_recorder (.i_clk(i_clk), .i_srst(srst),
        .i_expanded_mem(expm), .i_record_count_setting(code),
        .i_pretrigger_cycle_count(pre), .i_split_end_percentage(pct),
        .i_sample_valid(sv), .i_sample(sd), .i_trigger(tr),
        .i_fault_active(fa), .i_read_start(rs), .i_read_slot(slot),
        .o_read_busy(busy), .o_out_valid(ov), .o_out_data(od),
        .o_out_last(ol), .i_out_ready(rdy), .o_capturing(cap),
        .o_stored_count(cnt), .o_newest_slot(newest));
    relay_source u_relay_source (.i_clk(i_clk), .o_sample_valid(sv),
        .o_sample(sd), .o_trigger(tr), .o_fault_active(fa));
    task automatic check(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Odd events overrun the fault portion, so the split is exercised.
    task automatic run_one(input int c, input int i);
        int p, fn, tl, nf, k, n, r;
        logic [15:0] e[$];
        r = rtab[c];
        p = (i == 0) ? ((c % 2) ? 8 : 1) : $urandom_range(8, 1);
        fn = (ctab[c % 4] - p) * 64;
        nf = (i % 2) ? fn + $urandom_range(300, 1) : $urandom_range(200, 1);
        tl = (i == 1) ? (c % 2) * 100 : $urandom_range(100);
        pre <= 4'(p);
        pct <= 7'(tl);
        u_relay_source.run_event($urandom_range(600), nf, i % 2);
        check("stored", cnt, 16'(i + 1 < r ? i + 1 : r));
        check("newest", newest, 16'(i % r));
        tl = fn * tl / 100;
        k = u_relay_source.pre_q.size();
        for (int j = (k > p * 64 ? k - p * 64 : 0); j < k; j++)
            e.push_back(u_relay_source.pre_q[j]);
        for (int j = 0; j < nf; j++)
            if (nf <= fn || j < fn - tl || j >= nf - tl)
                e.push_back(u_relay_source.flt_q[j]);
        rs <= 1'b1;
        slot <= 6'(i % r);
        @(posedge i_clk);
        rs <= 1'b0;
        n = 0;
        k = 0;
        while ((n < e.size() || busy !== 1'b0) && k < 20000) begin
            @(posedge i_clk);
            k++;
            if (ov === 1'b1 && rdy === 1'b1) begin
                check("extra", 16'(n >= e.size()), 16'h0000);
                check("data", od, n < e.size() ? e[n] : 16'hxxxx);
                check("last", ol, n == e.size() - 1);
                n++;
            end
            rdy <= ($urandom_range(7) > 2);
        end
        if (k >= 20000) begin
            failures++;
            report_and_stop();
        end
        @(posedge i_clk);
        check("drained", ov, 1'b0);
    endtask
    initial begin
        void'($urandom(32'hd899fdd8));
        for (int c = 0; c < 8; c++) begin
            @(posedge i_clk);
            srst <= 1'b1;
            expm <= (c >= 4);
            code <= 2'(c);
            repeat (3) @(posedge i_clk);
            srst <= 1'b0;
            rs <= 1'b1;
            slot <= 6'd0;
            @(posedge i_clk);
            rs <= 1'b0;
            @(posedge i_clk);
            check("refused", busy, 1'b0);
            for (int i = 0; i < ((c == 3) ? 13 : 2); i++)
                run_one(c, i);
            $display("config %0d done", c);
        end
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
